/* File: pkg/psa_pkg.sv */
package psa_pkg;
  localparam int ADC_W = 10;
  localparam int CLK_HZ = 100_000_000;
  localparam int PWM_HZ = 1000;
  localparam int PWM_CYC_DEF = CLK_HZ / PWM_HZ;
  localparam int PWM_CYC_MIN = 1024;
  localparam logic [9:0] FULL = 10'h03ff;
  localparam logic [9:0] HALF = 10'h0200;
  localparam logic [7:0] DIN_LOW_MASK = 8'h03;
  localparam int DI_DIS_A = 0;
  localparam int DI_DIS_B = 1;
  localparam int DI_EN = 2;
  localparam int DI_SEL_B = 3;
  localparam int DI_RAMP_OFF = 4;
  localparam int DI_FIX_LSB = 5;
  localparam int REG_STEP = 4;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_WIN0 = 8'h04;
  localparam logic [7:0] A_FIX1 = 8'h14;
  localparam logic [7:0] A_CUR0 = 8'h30;
  localparam logic [7:0] A_RAMP0 = 8'h38;
  localparam logic [7:0] A_DITHER = 8'h40;
  localparam logic [7:0] A_STATUS = 8'h44;
  localparam logic [7:0] A_CMD = 8'h48;
  localparam int CT_MODE_LSB = 0;
  localparam int CT_INV = 2;
  localparam int CT_SRC_A_LSB = 4;
  localparam int CT_SRC_B_LSB = 6;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;
  localparam int FIX_SOL_B = 16;
  localparam int RAMP_UP_LSB = 0;
  localparam int RAMP_DN_LSB = 16;
  localparam int DITH_HALF_LSB = 0;
  localparam int DITH_AMP_LSB = 24;
  localparam int CMD_CLR_ERR = 0;
  localparam int CMD_SAVE = 1;
  localparam int ST_FAULT = 0;
  localparam int ST_SEL_B = 1;
  localparam int ST_DUTY_A_LSB = 12;
  localparam int ST_DUTY_B_LSB = 22;
  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] WIN_RST = 32'h03ff_0000;
  localparam logic [31:0] FIX_RST = 32'h0000_0000;
  localparam logic [31:0] CUR_RST = 32'h03ff_0000;
  localparam logic [31:0] RAMP_RST = 32'h0000_0000;
  localparam logic [31:0] DITH_RST = 32'h0007_a120;

  typedef enum logic [1:0] {
    MODE_DIR_INPUT,
    MODE_SPLIT,
    MODE_SIGNED,
    MODE_INDEP
  } psa_mode_t;

  typedef struct packed {
    logic en;
    logic [9:0] duty;
    logic [23:0] dith_half;
    logic [7:0] dith_amp;
  } psa_drive_t;
endpackage

/* File: verilog/psa_pwm.sv */
`timescale 1ns/1ps
module psa_pwm
  import psa_pkg::*;
#(
  parameter int CYC = PWM_CYC_DEF
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire psa_drive_t drive_i,
  output logic pwm_o
);
  // one bit of headroom so that a power-of-two period still fits in the scale factor
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  localparam logic [CW-1:0] CYC_W = CW'(CYC);

  logic [CW-1:0] cnt_q;
  logic [23:0] dcnt_q;
  logic phase_q;
  logic pwm_q;
  logic [10:0] eff;
  logic [9:0] duty_eff;
  logic [CW+9:0] prod;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= '0;
    else
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
  end

  // dither runs free so that both solenoids keep a steady wobble
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dcnt_q <= '0;
      phase_q <= 1'b0;
    end
    else if (drive_i.dith_half == '0)
      dcnt_q <= '0;
    else if (dcnt_q >= drive_i.dith_half - 24'd1)
    begin
      dcnt_q <= '0;
      phase_q <= ~phase_q;
    end
    else
      dcnt_q <= dcnt_q + 24'd1;
  end

  always_comb
  begin
    if (phase_q)
      eff = {1'b0, drive_i.duty} + {3'b0, drive_i.dith_amp};
    else
      eff = {1'b0, drive_i.duty} - {3'b0, drive_i.dith_amp};
    if (phase_q && eff[10])
      duty_eff = FULL;
    else if (!phase_q && eff[10])
      duty_eff = '0;
    else
      duty_eff = eff[9:0];
    prod = duty_eff * CYC_W;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pwm_q <= 1'b0;
    else
      pwm_q <= drive_i.en && (cnt_q < prod[CW+9:10]);
  end

  assign pwm_o = pwm_q;

  property p_wrap;
    @(posedge clk_i) disable iff (!rst_n_i)
    cnt_q == LAST |=> cnt_q == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pwm period did not wrap");

  property p_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    !drive_i.en |=> !pwm_q;
  endproperty
  a_off: assert property (p_off) else $error("pwm active while disabled");
endmodule // psa_pwm

/* File: verilog/psa_ctrl_top.sv */
`timescale 1ns/1ps
module psa_ctrl_top
  import psa_pkg::*;
#(
  parameter int PWM_CYC = PWM_CYC_DEF
)(
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] BUS_ADDR_I,
  input wire logic [31:0] BUS_WDATA_I,
  input wire logic BUS_WR_I,
  input wire logic BUS_RD_I,
  output logic [31:0] BUS_RDATA_O,
  input wire logic [3:0][ADC_W-1:0] AIN_I,
  input wire logic [7:0] DIN_I,
  input wire logic FAULT_I,
  output logic SOL_A_PWM_O,
  output logic SOL_B_PWM_O,
  output logic ERR_O,
  output logic SOL_B_ACT_O,
  output logic LED_YEL_O,
  output logic LED_RED_O,
  output logic NVM_SAVE_O,
  output logic NVM_LOAD_O
);
  if (PWM_CYC < PWM_CYC_MIN)
  begin : g_chk
    $error("PWM_CYC too small for 10-bit duty resolution");
  end

  logic [31:0] ctrl_q;
  logic [31:0] win_q [4];
  logic [31:0] fix_q [7];
  logic [31:0] cur_q [2];
  logic [31:0] rcfg_q [2];
  logic [31:0] dith_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic fault_q;
  logic save_q;
  logic boot_q;
  logic load_q;
  logic [7:0] act;
  logic [9:0] sp [4];
  logic [9:0] sp_a;
  logic [9:0] s3_mag;
  logic [2:0] fix_code;
  logic [9:0] fix_val;
  logic fix_b;
  logic [9:0] routed [2];
  logic sel_b;
  logic en_a;
  logic en_b;
  logic [9:0] tgt_q [2];
  logic en_q [2];
  logic sel_b_q;
  logic [9:0] ramp_q [2];
  logic [15:0] rcnt_q [2];
  logic [15:0] rate [2];
  logic [9:0] duty_q [2];
  psa_mode_t mode;
  psa_drive_t drv_a;
  psa_drive_t drv_b;

  function automatic logic [7:0] reg_addr(logic [7:0] base, int idx);
    return base + 8'(idx * REG_STEP);
  endfunction

  // offset is the window floor; codes below it read 0, above the top saturate
  function automatic logic [9:0] window(logic [9:0] ain, logic [31:0] cfg);
    logic [9:0] lo;
    logic [9:0] hi;
    lo = cfg[LO_LSB +: 10];
    hi = cfg[HI_LSB +: 10];
    if (ain <= lo || hi <= lo)
      return '0;
    if (ain >= hi)
      return hi - lo;
    return ain - lo;
  endfunction

  function automatic logic [9:0] dbl(logic [9:0] v);
    return v[9] ? FULL : {v[8:0], 1'b0};
  endfunction

  function automatic logic [9:0] scale(logic [9:0] r, logic [31:0] cfg);
    logic [9:0] lo;
    logic [9:0] hi;
    logic [19:0] p;
    lo = cfg[LO_LSB +: 10];
    hi = cfg[HI_LSB +: 10];
    p = r * (hi - lo);
    if (hi <= lo)
      return lo;
    return lo + p[19:10];
  endfunction

  // register writes
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_q <= CTRL_RST;
      dith_q <= DITH_RST;
      for (int i = 0; i < 4; i++)
        win_q[i] <= WIN_RST;
      for (int i = 0; i < 7; i++)
        fix_q[i] <= FIX_RST;
      for (int i = 0; i < 2; i++)
      begin
        cur_q[i] <= CUR_RST;
        rcfg_q[i] <= RAMP_RST;
      end
    end
    else if (BUS_WR_I)
    begin
      if (BUS_ADDR_I == A_CTRL)
        ctrl_q <= BUS_WDATA_I;
      if (BUS_ADDR_I == A_DITHER)
        dith_q <= BUS_WDATA_I;
      for (int i = 0; i < 4; i++)
        if (BUS_ADDR_I == reg_addr(A_WIN0, i))
          win_q[i] <= BUS_WDATA_I;
      for (int i = 0; i < 7; i++)
        if (BUS_ADDR_I == reg_addr(A_FIX1, i))
          fix_q[i] <= BUS_WDATA_I;
      for (int i = 0; i < 2; i++)
      begin
        if (BUS_ADDR_I == reg_addr(A_CUR0, i))
          cur_q[i] <= BUS_WDATA_I;
        if (BUS_ADDR_I == reg_addr(A_RAMP0, i))
          rcfg_q[i] <= BUS_WDATA_I;
      end
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb
  begin
    rd_d = '0;
    if (BUS_ADDR_I == A_CTRL)
      rd_d = ctrl_q;
    if (BUS_ADDR_I == A_DITHER)
      rd_d = dith_q;
    for (int i = 0; i < 4; i++)
      if (BUS_ADDR_I == reg_addr(A_WIN0, i))
        rd_d = win_q[i];
    for (int i = 0; i < 7; i++)
      if (BUS_ADDR_I == reg_addr(A_FIX1, i))
        rd_d = fix_q[i];
    for (int i = 0; i < 2; i++)
    begin
      if (BUS_ADDR_I == reg_addr(A_CUR0, i))
        rd_d = cur_q[i];
      if (BUS_ADDR_I == reg_addr(A_RAMP0, i))
        rd_d = rcfg_q[i];
    end
    if (BUS_ADDR_I == A_STATUS)
    begin
      rd_d[ST_FAULT] = fault_q;
      rd_d[ST_SEL_B] = sel_b_q;
      rd_d[ST_DUTY_A_LSB +: 10] = duty_q[0];
      rd_d[ST_DUTY_B_LSB +: 10] = duty_q[1];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rdata_q <= '0;
    else
      rdata_q <= BUS_RD_I ? rd_d : '0;
  end

  // a new fault in the clearing cycle wins, so no event is lost
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      fault_q <= 1'b0;
    else if (FAULT_I)
      fault_q <= 1'b1;
    else if (BUS_WR_I && BUS_ADDR_I == A_CMD && BUS_WDATA_I[CMD_CLR_ERR])
      fault_q <= 1'b0;
  end

  // storage itself is outside; the block only requests save and reload
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      save_q <= 1'b0;
      boot_q <= 1'b0;
      load_q <= 1'b0;
    end
    else
    begin
      save_q <= BUS_WR_I && BUS_ADDR_I == A_CMD && BUS_WDATA_I[CMD_SAVE];
      boot_q <= 1'b1;
      load_q <= !boot_q;
    end
  end

  assign act = DIN_I ^ DIN_LOW_MASK;
  assign mode = psa_mode_t'(ctrl_q[CT_MODE_LSB +: 2]);
  assign fix_code = act[DI_FIX_LSB +: 3];
  assign fix_val = (fix_code != '0) ? fix_q[fix_code - 3'd1][9:0] : '0;
  assign fix_b = (fix_code != '0) && fix_q[fix_code - 3'd1][FIX_SOL_B];
  assign en_a = act[DI_EN] && !act[DI_DIS_A];
  assign en_b = act[DI_EN] && !act[DI_DIS_B];

  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      sp[k] = window(AIN_I[k], win_q[k]);
      if (ctrl_q[CT_INV])
        sp[k] = FULL - sp[k];
    end
  end

  assign sp_a = sp[ctrl_q[CT_SRC_A_LSB +: 2]];
  // input 3 carries the bipolar setpoint as a two's complement code
  assign s3_mag = AIN_I[2][9] ? 10'h0000 - AIN_I[2] : AIN_I[2];

  always_comb
  begin
    routed[0] = '0;
    routed[1] = '0;
    sel_b = 1'b0;
    case (mode)
      MODE_DIR_INPUT:
      begin
        sel_b = act[DI_SEL_B];
        if (act[DI_SEL_B])
          routed[1] = sp_a;
        else
          routed[0] = sp_a;
      end
      MODE_SPLIT:
      begin
        sel_b = sp_a < HALF;
        if (sp_a < HALF)
          routed[1] = dbl(HALF - 10'h0001 - sp_a);
        else
          routed[0] = dbl(sp_a - HALF);
      end
      MODE_SIGNED:
      begin
        sel_b = AIN_I[2][9];
        if (AIN_I[2][9])
          routed[1] = dbl(s3_mag);
        else
          routed[0] = dbl(s3_mag);
      end
      MODE_INDEP:
      begin
        routed[0] = sp_a;
        routed[1] = sp[ctrl_q[CT_SRC_B_LSB +: 2]];
        sel_b = routed[1] != '0;
      end
      default:
      begin
        routed[0] = '0;
      end
    endcase
    if (fix_code != '0)
    begin
      routed[0] = fix_b ? '0 : fix_val;
      routed[1] = fix_b ? fix_val : '0;
      sel_b = fix_b;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      tgt_q[0] <= '0;
      tgt_q[1] <= '0;
      en_q[0] <= 1'b0;
      en_q[1] <= 1'b0;
      sel_b_q <= 1'b0;
    end
    else
    begin
      tgt_q[0] <= en_a ? routed[0] : '0;
      tgt_q[1] <= en_b ? routed[1] : '0;
      en_q[0] <= en_a;
      en_q[1] <= en_b;
      sel_b_q <= sel_b && en_b;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
      if (tgt_q[i] > ramp_q[i])
        rate[i] = rcfg_q[i][RAMP_UP_LSB +: 16];
      else
        rate[i] = rcfg_q[i][RAMP_DN_LSB +: 16];
  end

  // rate is clock cycles per code step, so full travel is 1023 steps
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < 2; i++)
      begin
        ramp_q[i] <= '0;
        rcnt_q[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!en_q[i])
        begin
          ramp_q[i] <= '0;
          rcnt_q[i] <= '0;
        end
        else if (act[DI_RAMP_OFF] || rate[i] == '0 || ramp_q[i] == tgt_q[i])
        begin
          ramp_q[i] <= tgt_q[i];
          rcnt_q[i] <= '0;
        end
        else if (rcnt_q[i] >= rate[i] - 16'h0001)
        begin
          rcnt_q[i] <= '0;
          ramp_q[i] <= (tgt_q[i] > ramp_q[i]) ? ramp_q[i] + 10'h0001 : ramp_q[i] - 10'h0001;
        end
        else
          rcnt_q[i] <= rcnt_q[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      duty_q[0] <= '0;
      duty_q[1] <= '0;
    end
    else
    begin
      duty_q[0] <= en_q[0] ? scale(ramp_q[0], cur_q[0]) : '0;
      duty_q[1] <= en_q[1] ? scale(ramp_q[1], cur_q[1]) : '0;
    end
  end

  assign drv_a = '{en: en_q[0], duty: duty_q[0], dith_half: dith_q[DITH_HALF_LSB +: 24],
                   dith_amp: dith_q[DITH_AMP_LSB +: 8]};
  assign drv_b = '{en: en_q[1], duty: duty_q[1], dith_half: dith_q[DITH_HALF_LSB +: 24],
                   dith_amp: dith_q[DITH_AMP_LSB +: 8]};

  psa_pwm #(.CYC(PWM_CYC)) u_pwm_a (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .drive_i(drv_a),
    .pwm_o(SOL_A_PWM_O)
  );

  psa_pwm #(.CYC(PWM_CYC)) u_pwm_b (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .drive_i(drv_b),
    .pwm_o(SOL_B_PWM_O)
  );

  assign BUS_RDATA_O = rdata_q;
  assign ERR_O = fault_q;
  assign LED_RED_O = fault_q;
  assign SOL_B_ACT_O = sel_b_q;
  assign LED_YEL_O = sel_b_q;
  assign NVM_SAVE_O = save_q;
  assign NVM_LOAD_O = load_q;

  property p_dis_a;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    act[DI_DIS_A] |-> ##2 duty_q[0] == '0;
  endproperty
  a_dis_a: assert property (p_dis_a) else $error("solenoid A driven while disabled");

  property p_dis_b;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    act[DI_DIS_B] |-> ##2 duty_q[1] == '0;
  endproperty
  a_dis_b: assert property (p_dis_b) else $error("solenoid B driven while disabled");

  property p_enable;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    !act[DI_EN] |-> ##2 (duty_q[0] == '0 && duty_q[1] == '0);
  endproperty
  a_enable: assert property (p_enable) else $error("outputs driven without enable");

  property p_mode1;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    mode == MODE_DIR_INPUT && en_b && act[DI_SEL_B] && fix_code == '0
      |=> tgt_q[0] == '0 && tgt_q[1] == $past(sp_a);
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 did not select solenoid B");

  property p_mode2;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    mode == MODE_SPLIT && fix_code == '0 && sp_a >= HALF |=> tgt_q[1] == '0;
  endproperty
  a_mode2: assert property (p_mode2) else $error("mode 2 upper half reached B");

  property p_mode3;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    mode == MODE_SIGNED && fix_code == '0 && AIN_I[2][9] |=> tgt_q[0] == '0;
  endproperty
  a_mode3: assert property (p_mode3) else $error("mode 3 negative reached A");

  property p_ramp_off;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    en_q[0] && act[DI_RAMP_OFF] |=> ramp_q[0] == $past(tgt_q[0]);
  endproperty
  a_ramp_off: assert property (p_ramp_off) else $error("ramp not bypassed");

  property p_ramp_zero;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    en_q[1] && rcfg_q[1] == '0 |=> ramp_q[1] == $past(tgt_q[1]);
  endproperty
  a_ramp_zero: assert property (p_ramp_zero) else $error("zero ramp not transparent");

  property p_preset;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    fix_code != '0 && !fix_b && en_a |=> tgt_q[0] == $past(fix_val) && tgt_q[1] == '0;
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not override setpoint");

  property p_fault;
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    FAULT_I |=> ERR_O && LED_RED_O;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not shown");
endmodule // psa_ctrl_top

/* File: verification/psa_valve_model.sv */
`timescale 1ns/1ps
module psa_valve_model
  import psa_pkg::*;
#(
  parameter int WIN = 1024
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [ADC_W-1:0] sp_i,
  input wire logic [7:0] cmd_i,
  input wire logic sol_a_i,
  input wire logic sol_b_i,
  output logic [3:0][ADC_W-1:0] ain_o,
  output logic [7:0] din_o,
  output logic [15:0] hi_a_o,
  output logic [15:0] hi_b_o
);
  logic [15:0] cyc_q;
  logic [15:0] acc_a_q;
  logic [15:0] acc_b_q;
  // every source carries one setpoint, so routing is judged and not the source field
  assign ain_o = {4{sp_i}};
  // the source side raises input 4 itself to pick solenoid B
  assign din_o = cmd_i;
  // high time per window; a window of one carrier period is phase independent
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cyc_q <= '0;
      acc_a_q <= '0;
      acc_b_q <= '0;
      hi_a_o <= '0;
      hi_b_o <= '0;
    end
    else if (cyc_q == 16'(WIN - 1))
    begin
      cyc_q <= '0;
      hi_a_o <= acc_a_q + 16'(sol_a_i);
      hi_b_o <= acc_b_q + 16'(sol_b_i);
      acc_a_q <= '0;
      acc_b_q <= '0;
    end
    else
    begin
      cyc_q <= cyc_q + 16'h0001;
      acc_a_q <= acc_a_q + 16'(sol_a_i);
      acc_b_q <= acc_b_q + 16'(sol_b_i);
    end
  end
endmodule // psa_valve_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import psa_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] din;
    logic [9:0] ain;
    logic [9:0] da;
    logic [9:0] db;
    logic sb;
  } psa_row_t;
  localparam int CYC = PWM_CYC_MIN;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr_s = 8'h00;
  logic [31:0] wdata_s = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic [9:0] sp = 10'h0000;
  logic [7:0] cmd = 8'h03;
  logic fault = 1'b0;
  logic [3:0][ADC_W-1:0] ain;
  logic [7:0] din;
  logic sol_a, sol_b, err, sel_b, yel, red, nvm_save, nvm_load;
  logic [15:0] hi_a, hi_b;
  logic [9:0] cmn = 10'h0000;
  logic [9:0] cmx = 10'h03ff;
  int n_errors = 0;
  int num_checks = 0;

  psa_ctrl_top #(.PWM_CYC(CYC)) psa_ctrl_top_i (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .BUS_ADDR_I(addr_s),
    .BUS_WDATA_I(wdata_s), .BUS_WR_I(wr_s), .BUS_RD_I(rd_s), .BUS_RDATA_O(rdata), .AIN_I(ain), .DIN_I(din),
    .FAULT_I(fault), .SOL_A_PWM_O(sol_a), .SOL_B_PWM_O(sol_b), .ERR_O(err), .SOL_B_ACT_O(sel_b),
    .LED_YEL_O(yel), .LED_RED_O(red), .NVM_SAVE_O(nvm_save), .NVM_LOAD_O(nvm_load));
  psa_valve_model #(.WIN(CYC)) psa_valve_model_i (.clk_i(ref_clk), .rst_n_i(rst_n), .sp_i(sp), .cmd_i(cmd),
    .sol_a_i(sol_a), .sol_b_i(sol_b), .ain_o(ain), .din_o(din), .hi_a_o(hi_a), .hi_b_o(hi_b));

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected duty from the scaling between minimum and maximum
  function automatic logic [9:0] sc(input logic [9:0] x);
    logic [19:0] p;
    p = x * (cmx - cmn);
    return cmn + p[19:10];
  endfunction

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr_s <= a;
    wdata_s <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk);
    wr_s <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr_s <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic run(input psa_row_t r);
    logic [31:0] s;
    bus_wr(A_CTRL, {24'h00_0000, r.ctrl});
    sp <= r.ain;
    cmd <= r.din;
    repeat (8) @(posedge ref_clk);
    bus_rd(A_STATUS, s);
    chk(32'(s[ST_DUTY_A_LSB +: 10]), 32'(r.da));
    chk(32'(s[ST_DUTY_B_LSB +: 10]), 32'(r.db));
    chk(32'({s[ST_SEL_B], sel_b}), 32'({r.sb, r.sb}));
    chk(32'(yel), 32'(r.sb));
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end

  initial
  begin
    logic [31:0] s;
    int cnt;
    psa_row_t rows[13];
    logic [7:0] ra[8];
    logic [31:0] rv[8];
    ra = '{A_CTRL, A_WIN0, A_FIX1, A_CUR0, A_RAMP0, A_DITHER, A_CMD, 8'h80};
    rv = '{CTRL_RST, WIN_RST, FIX_RST, CUR_RST, RAMP_RST, DITH_RST, 32'h0000_0000, 32'h0000_0000};
    rows = '{'{8'h10, 8'h07, 10'h0200, sc(10'h0200), 10'h0000, 1'b0}, '{8'h10, 8'h0f, 10'h0200, 10'h0000,
      sc(10'h0200), 1'b1}, '{8'h10, 8'h0b, 10'h0200, 10'h0000, 10'h0000, 1'b0}, '{8'h10, 8'h06, 10'h0200,
      10'h0000, 10'h0000, 1'b0}, '{8'h10, 8'h0d, 10'h0200, 10'h0000, 10'h0000, 1'b0}, '{8'h11, 8'h07,
      10'h0100, 10'h0000, sc(10'h01fe), 1'b1}, '{8'h11, 8'h07, 10'h0300, sc(10'h0200), 10'h0000, 1'b0},
      '{8'h12, 8'h07, 10'h0040, sc(10'h0080), 10'h0000, 1'b0}, '{8'h12, 8'h07, 10'h03c0, 10'h0000,
      sc(10'h0080), 1'b1}, '{8'h13, 8'h05, 10'h0200, sc(10'h0200), 10'h0000, 1'b0}, '{8'h14, 8'h07,
      10'h0100, sc(10'h02ff), 10'h0000, 1'b0}, '{8'h10, 8'h27, 10'h03ff, sc(10'h0100), 10'h0000, 1'b0},
      '{8'h10, 8'he7, 10'h03ff, 10'h0000, sc(10'h0080), 1'b1}};
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(32'(nvm_load), 32'h0000_0001);
    @(posedge ref_clk);
    #1;
    chk(32'(nvm_load), 32'h0000_0000);
    bus_wr(8'h80, 32'hffff_ffff);
    bus_wr(A_CMD, 32'h0000_0000);
    foreach (ra[i])
    begin
      bus_rd(ra[i], s);
      chk(s, rv[i]);
    end
    bus_wr(A_FIX1, 32'h0000_0100);
    bus_wr(A_FIX1 + 8'h18, 32'h0001_0080);
    // rows cover modes, gating, inversion and presets; ramp time zero keeps them immediate
    foreach (rows[i])
      run(rows[i]);
    run(rows[0]);
    repeat (3 * CYC) @(posedge ref_clk);
    chk(32'(hi_a), 32'(sc(10'h0200)));
    chk(32'(hi_b), 32'h0000_0000);
    run(rows[1]);
    repeat (3 * CYC) @(posedge ref_clk);
    chk(32'(hi_b), 32'(sc(10'h0200)));
    chk(32'(hi_a), 32'h0000_0000);
    fault <= 1'b1;
    bus_wr(A_CMD, 32'h0000_0001);
    fault <= 1'b0;
    #1;
    chk(32'({err, red}), 32'h0000_0003);
    bus_rd(A_STATUS, s);
    chk(32'(s[ST_FAULT]), 32'h0000_0001);
    bus_wr(A_CMD, 32'h0000_0001);
    @(posedge ref_clk);
    #1;
    chk(32'({err, red}), 32'h0000_0000);
    bus_wr(A_CMD, 32'h0000_0002);
    cnt = 0;
    repeat (3)
    begin
      #1;
      cnt += int'(nvm_save);
      @(posedge ref_clk);
    end
    chk(32'(cnt), 32'h0000_0001);
    // window 0x100..0x300 on every input, then current limits 0x100..0x200
    for (int k = 0; k < 4; k++)
      bus_wr(A_WIN0 + 8'(k * REG_STEP), 32'h0300_0100);
    run('{8'h10, 8'h07, 10'h0080, 10'h0000, 10'h0000, 1'b0});
    run('{8'h10, 8'h07, 10'h0200, sc(10'h0100), 10'h0000, 1'b0});
    bus_wr(A_CUR0, 32'h0200_0100);
    cmn = 10'h0100;
    cmx = 10'h0200;
    run('{8'h10, 8'h07, 10'h0200, sc(10'h0100), 10'h0000, 1'b0});
    run('{8'h10, 8'h07, 10'h0100, sc(10'h0000), 10'h0000, 1'b0});
    bus_wr(A_RAMP0, 32'h0000_0004);
    sp <= 10'h0110;
    repeat (10) @(posedge ref_clk);
    bus_rd(A_STATUS, s);
    chk(32'(s[ST_DUTY_A_LSB +: 10] < sc(10'h0010)), 32'h0000_0001);
    repeat (150) @(posedge ref_clk);
    bus_rd(A_STATUS, s);
    chk(32'(s[ST_DUTY_A_LSB +: 10]), 32'(sc(10'h0010)));
    @(posedge ref_clk);
    cmd <= 8'h17;
    sp <= 10'h0300;
    repeat (8) @(posedge ref_clk);
    bus_rd(A_STATUS, s);
    chk(32'(s[ST_DUTY_A_LSB +: 10]), 32'(sc(10'h0200)));
    test_done();
  end
endmodule // tb_top
